//--- hdl/fqh_consts.svh
// offsets, field positions, query command values and timing counts of the flash query host
`ifndef FQH_CONSTS_SVH
`define FQH_CONSTS_SVH

`define FQH_AW 23
`define FQH_DW 16

// own register map, byte addresses on apb
`define FQH_REG_CTRL 8'h00
`define FQH_REG_ADDR 8'h04
`define FQH_REG_WDATA 8'h08
`define FQH_REG_RDATA 8'h0c
`define FQH_REG_STATUS 8'h10
`define FQH_REG_MISADDR 8'h14

// control fields
`define FQH_CTRL_START 0
`define FQH_CTRL_OP_LO 1
`define FQH_CTRL_OP_HI 3
`define FQH_CTRL_OTHER_BUSY 4
`define FQH_CTRL_SUSPENDED 5

// status fields
`define FQH_ST_BUSY 0
`define FQH_ST_DONE 1
`define FQH_ST_REFUSED 2
`define FQH_ST_MISMATCH 3
`define FQH_ST_ERR_RESET 4
`define FQH_ST_MODE_LO 5
`define FQH_ST_MODE_HI 6
`define FQH_ST_ESR 7

// query entry command and the poll timeout error bit
`define FQH_QUERY_ADDR 23'h000055
`define FQH_QUERY_DATA 16'h0098
`define FQH_TIMEOUT_ERR_BIT 5

// span of the geometry and extended query check
`define FQH_VFY_FIRST 7'h27
`define FQH_VFY_LAST 7'h5b

// bus cycle timing
`define FQH_CLK_NS 10
`define FQH_T_SETUP_NS 20
`define FQH_T_WP_NS 50
`define FQH_T_OE_NS 100
`define FQH_T_HOLD_NS 20
`define FQH_CYC_MIN(ns) (((ns) + `FQH_CLK_NS - 1) / `FQH_CLK_NS)

`endif

//--- hdl/fqh_pkg.sv
// types shared by the flash query host and its bus cycle engine
package fqh_pkg;
   `include "fqh_consts.svh"

   typedef enum logic [2:0] {
      OP_READ,
      OP_WRITE,
      OP_RESET,
      OP_AUTOSEL,
      OP_QUERY,
      OP_VERIFY,
      OP_POLL
   } fqh_op_t;

   typedef enum logic [1:0] {
      MD_READ,
      MD_AUTOSEL,
      MD_QUERY
   } fqh_mode_t;

   // one bus cycle as handed to the engine
   typedef struct packed {
      logic last;
      logic is_wr;
      logic [`FQH_AW-1:0] addr;
      logic [`FQH_DW-1:0] data;
   } fqh_cyc_t;

   // flash side pins, dq split into out and enable
   typedef struct packed {
      logic cs_n;
      logic we_n;
      logic oe_n;
      logic [`FQH_AW-1:0] addr;
      logic [`FQH_DW-1:0] dq_out;
      logic dq_oe;
   } fqh_pins_t;
endpackage

//--- hdl/fqh_bus_cycle.sv
// single asynchronous flash read or write cycle on the parallel pins
`timescale 1ns/1ps
`include "fqh_consts.svh"
module fqh_bus_cycle import fqh_pkg::*; #(
   parameter logic [7:0] SETUP_CYC = 8'(`FQH_CYC_MIN(`FQH_T_SETUP_NS)),
   parameter logic [7:0] WP_CYC = 8'(`FQH_CYC_MIN(`FQH_T_WP_NS)),
   parameter logic [7:0] OE_CYC = 8'(`FQH_CYC_MIN(`FQH_T_OE_NS)),
   parameter logic [7:0] HOLD_CYC = 8'(`FQH_CYC_MIN(`FQH_T_HOLD_NS))
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // cycle request
   input wire logic go_in,
   input wire fqh_cyc_t cyc_in,
   output logic done_out,
   output logic [`FQH_DW-1:0] rdata_out,
   // flash pins
   output fqh_pins_t pins_out,
   input wire logic [`FQH_DW-1:0] dq_in
);
   typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} fqh_ph_t;

   typedef struct packed {
      fqh_ph_t ph;
      logic [7:0] cnt;
      logic is_wr;
      logic done;
      logic [`FQH_DW-1:0] rdata;
      fqh_pins_t pins;
   } fqh_bc_st_t;

   fqh_bc_st_t s_r;
   fqh_bc_st_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      unique case (s_r.ph)
         PH_IDLE: begin
            if (go_in) begin
               // address settles with cs low, so the later falling edge is we or oe
               s_nxt.is_wr = cyc_in.is_wr;
               s_nxt.pins.addr = cyc_in.addr;
               s_nxt.pins.dq_out = cyc_in.data;
               s_nxt.pins.dq_oe = cyc_in.is_wr;
               s_nxt.pins.cs_n = 1'b0;
               s_nxt.pins.oe_n = 1'b1;
               s_nxt.pins.we_n = 1'b1;
               s_nxt.cnt = SETUP_CYC - 8'h01;
               s_nxt.ph = PH_SETUP;
            end
         end
         PH_SETUP: begin
            if (s_r.cnt == 8'h00) begin
               if (s_r.is_wr) begin
                  s_nxt.pins.we_n = 1'b0;
                  s_nxt.cnt = WP_CYC - 8'h01;
               end else begin
                  s_nxt.pins.oe_n = 1'b0;
                  s_nxt.cnt = OE_CYC - 8'h01;
               end
               s_nxt.ph = PH_STROBE;
            end else begin
               s_nxt.cnt = s_r.cnt - 8'h01;
            end
         end
         PH_STROBE: begin
            if (s_r.cnt == 8'h00) begin
               // we rises before cs, so data is taken on the we edge with dq still driven
               if (s_r.is_wr) begin
                  s_nxt.pins.we_n = 1'b1;
               end else begin
                  s_nxt.rdata = dq_in;
                  s_nxt.pins.oe_n = 1'b1;
               end
               s_nxt.cnt = HOLD_CYC - 8'h01;
               s_nxt.ph = PH_HOLD;
            end else begin
               s_nxt.cnt = s_r.cnt - 8'h01;
            end
         end
         PH_HOLD: begin
            if (s_r.cnt == 8'h00) begin
               s_nxt.pins.cs_n = 1'b1;
               s_nxt.pins.dq_oe = 1'b0;
               s_nxt.done = 1'b1;
               s_nxt.ph = PH_IDLE;
            end else begin
               s_nxt.cnt = s_r.cnt - 8'h01;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         s_r <= '{ph: PH_IDLE, cnt: 8'h00, is_wr: 1'b0, done: 1'b0, rdata: '0,
                  pins: '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0}};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign done_out = s_r.done;
   assign rdata_out = s_r.rdata;
   assign pins_out = s_r.pins;
endmodule

//--- hdl/fqh_host.sv
// apb controlled host that drives a multi-bank nor flash through its command pins
`timescale 1ns/1ps
`include "fqh_consts.svh"
module fqh_host import fqh_pkg::*; #(
   parameter logic [`FQH_AW-1:0] UNLOCK1_ADDR = '0,
   parameter logic [`FQH_DW-1:0] UNLOCK1_DATA = '0,
   parameter logic [`FQH_AW-1:0] UNLOCK2_ADDR = '0,
   parameter logic [`FQH_DW-1:0] UNLOCK2_DATA = '0,
   parameter logic [`FQH_DW-1:0] AUTOSEL_DATA = '0,
   parameter logic [`FQH_DW-1:0] RESET_DATA = '0
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // flash pins
   output logic flash_cs_n_out,
   output logic flash_we_n_out,
   output logic flash_oe_n_out,
   output logic [`FQH_AW-1:0] flash_addr_out,
   output logic [`FQH_DW-1:0] flash_dq_out,
   output logic flash_dq_oe_out,
   input wire logic [`FQH_DW-1:0] flash_dq_in
);
   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} fqh_fsm_t;

   typedef struct packed {
      fqh_fsm_t fsm;
      fqh_op_t op;
      logic [1:0] step;
      logic [6:0] vaddr;
      logic [`FQH_AW-1:0] addr;
      logic [`FQH_DW-1:0] wdata;
      logic [`FQH_DW-1:0] rdata;
      logic [6:0] mis_addr;
      logic other_busy;
      logic suspended;
      fqh_mode_t mode;
      logic done;
      logic refused;
      logic mismatch;
      logic err_reset;
      logic [31:0] prdata;
   } fqh_host_st_t;

   fqh_host_st_t s_r;
   fqh_host_st_t s_nxt;

   fqh_cyc_t cyc;
   logic cyc_go;
   logic cyc_done;
   logic [`FQH_DW-1:0] cyc_rdata;
   fqh_pins_t pins;
   logic [16:0] expect_w;
   logic wr_hit;
   logic mapped;
   fqh_op_t req_op;
   logic req_ok;

   // expected query word, bit 16 set where the location is checked
   function automatic logic [16:0] query_word(input logic [6:0] a);
      logic [16:0] e;
      e = '0;
      unique case (a)
         7'h27: e = {1'b1, 16'h0018};
         7'h28: e = {1'b1, 16'h0001};
         7'h29, 7'h2a, 7'h2b: e = {1'b1, 16'h0000};
         7'h2c: e = {1'b1, 16'h0003};
         7'h2d, 7'h35: e = {1'b1, 16'h0007};
         7'h2e, 7'h30, 7'h36, 7'h38: e = {1'b1, 16'h0000};
         7'h2f, 7'h37: e = {1'b1, 16'h0020};
         7'h31: e = {1'b1, 16'h00fd};
         7'h32, 7'h33: e = {1'b1, 16'h0000};
         7'h34: e = {1'b1, 16'h0001};
         7'h39, 7'h3a, 7'h3b, 7'h3c: e = {1'b1, 16'h0000};
         7'h40: e = {1'b1, 16'h0050};
         7'h41: e = {1'b1, 16'h0052};
         7'h42: e = {1'b1, 16'h0049};
         7'h43: e = {1'b1, 16'h0031};
         7'h44: e = {1'b1, 16'h0033};
         7'h45: e = {1'b1, 16'h000c};
         7'h46: e = {1'b1, 16'h0002};
         7'h47, 7'h48: e = {1'b1, 16'h0001};
         7'h49: e = {1'b1, 16'h0007};
         7'h4a: e = {1'b1, 16'h00e7};
         7'h4b: e = {1'b1, 16'h0000};
         7'h4c: e = {1'b1, 16'h0002};
         7'h4d: e = {1'b1, 16'h0085};
         7'h4e: e = {1'b1, 16'h0095};
         7'h4f, 7'h50: e = {1'b1, 16'h0001};
         7'h57: e = {1'b1, 16'h0004};
         7'h58, 7'h5b: e = {1'b1, 16'h0027};
         7'h59, 7'h5a: e = {1'b1, 16'h0060};
         default: e = '0;
      endcase
      return e;
   endfunction

   // bus cycles of each operation; sequences are always issued whole
   always_comb begin
      cyc = '{last: 1'b1, is_wr: 1'b1, addr: s_r.addr, data: RESET_DATA};
      unique case (s_r.op)
         OP_READ, OP_POLL: begin
            cyc.is_wr = 1'b0;
         end
         OP_WRITE: begin
            cyc.data = s_r.wdata;
         end
         OP_RESET: begin
            // address bits are don't care to the device, the bank address is kept
            cyc.data = RESET_DATA;
         end
         OP_AUTOSEL: begin
            unique case (s_r.step)
               2'd0: cyc = '{last: 1'b0, is_wr: 1'b1, addr: UNLOCK1_ADDR, data: UNLOCK1_DATA};
               2'd1: cyc = '{last: 1'b0, is_wr: 1'b1, addr: UNLOCK2_ADDR, data: UNLOCK2_DATA};
               default: cyc = '{last: 1'b1, is_wr: 1'b1, addr: s_r.addr, data: AUTOSEL_DATA};
            endcase
         end
         OP_QUERY: begin
            cyc.addr = `FQH_QUERY_ADDR;
            cyc.data = `FQH_QUERY_DATA;
         end
         OP_VERIFY: begin
            cyc.is_wr = 1'b0;
            cyc.addr = `FQH_AW'(s_r.vaddr);
            cyc.last = (s_r.vaddr == `FQH_VFY_LAST);
         end
         default: cyc.is_wr = 1'b0;
      endcase
   end

   assign cyc_go = (s_r.fsm == ST_ISSUE);
   assign expect_w = query_word(s_r.vaddr);
   assign wr_hit = psel_in && penable_in && pwrite_in;
   assign mapped = (paddr_in == `FQH_REG_CTRL) || (paddr_in == `FQH_REG_ADDR) ||
                   (paddr_in == `FQH_REG_WDATA) || (paddr_in == `FQH_REG_RDATA) ||
                   (paddr_in == `FQH_REG_STATUS) || (paddr_in == `FQH_REG_MISADDR);
   assign req_op = fqh_op_t'(pwdata_in[`FQH_CTRL_OP_HI:`FQH_CTRL_OP_LO]);

   // legality of a new operation against the mode the host believes the bank is in
   always_comb begin
      unique case (req_op)
         OP_AUTOSEL: req_ok = (s_r.mode == MD_READ) && !pwdata_in[`FQH_CTRL_OTHER_BUSY];
         OP_QUERY: req_ok = (s_r.mode != MD_QUERY) && !pwdata_in[`FQH_CTRL_OTHER_BUSY];
         OP_VERIFY: req_ok = (s_r.mode == MD_QUERY);
         OP_READ, OP_WRITE, OP_RESET, OP_POLL: req_ok = 1'b1;
         default: req_ok = 1'b0;
      endcase
   end

   always_comb begin
      s_nxt = s_r;
      // register reads are latched in the setup cycle so prdata is a flop
      if (psel_in && !penable_in && !pwrite_in) begin
         s_nxt.prdata = '0;
         unique case (paddr_in)
            `FQH_REG_CTRL: begin
               s_nxt.prdata[`FQH_CTRL_OP_HI:`FQH_CTRL_OP_LO] = s_r.op;
               s_nxt.prdata[`FQH_CTRL_OTHER_BUSY] = s_r.other_busy;
               s_nxt.prdata[`FQH_CTRL_SUSPENDED] = s_r.suspended;
            end
            `FQH_REG_ADDR: s_nxt.prdata[`FQH_AW-1:0] = s_r.addr;
            `FQH_REG_WDATA: s_nxt.prdata[`FQH_DW-1:0] = s_r.wdata;
            `FQH_REG_RDATA: s_nxt.prdata[`FQH_DW-1:0] = s_r.rdata;
            `FQH_REG_STATUS: begin
               s_nxt.prdata[`FQH_ST_BUSY] = (s_r.fsm != ST_IDLE);
               s_nxt.prdata[`FQH_ST_DONE] = s_r.done;
               s_nxt.prdata[`FQH_ST_REFUSED] = s_r.refused;
               s_nxt.prdata[`FQH_ST_MISMATCH] = s_r.mismatch;
               s_nxt.prdata[`FQH_ST_ERR_RESET] = s_r.err_reset;
               s_nxt.prdata[`FQH_ST_MODE_HI:`FQH_ST_MODE_LO] = s_r.mode;
               // a suspended bank sits in suspend-read and returns status for its suspended sectors
               s_nxt.prdata[`FQH_ST_ESR] = s_r.suspended && (s_r.mode == MD_READ);
            end
            `FQH_REG_MISADDR: s_nxt.prdata[6:0] = s_r.mis_addr;
            default: s_nxt.prdata = '0;
         endcase
      end
      // clears come first so that a hardware set in the same cycle wins
      if (wr_hit) begin
         unique case (paddr_in)
            `FQH_REG_ADDR: s_nxt.addr = pwdata_in[`FQH_AW-1:0];
            `FQH_REG_WDATA: s_nxt.wdata = pwdata_in[`FQH_DW-1:0];
            `FQH_REG_STATUS: begin
               if (pwdata_in[`FQH_ST_DONE]) s_nxt.done = 1'b0;
               if (pwdata_in[`FQH_ST_REFUSED]) s_nxt.refused = 1'b0;
               if (pwdata_in[`FQH_ST_MISMATCH]) s_nxt.mismatch = 1'b0;
               if (pwdata_in[`FQH_ST_ERR_RESET]) s_nxt.err_reset = 1'b0;
            end
            `FQH_REG_CTRL: begin
               s_nxt.other_busy = pwdata_in[`FQH_CTRL_OTHER_BUSY];
               s_nxt.suspended = pwdata_in[`FQH_CTRL_SUSPENDED];
            end
            default: s_nxt.addr = s_r.addr;
         endcase
      end
      unique case (s_r.fsm)
         ST_IDLE: begin
            if (wr_hit && paddr_in == `FQH_REG_CTRL && pwdata_in[`FQH_CTRL_START]) begin
               if (req_ok) begin
                  s_nxt.op = req_op;
                  s_nxt.step = 2'd0;
                  s_nxt.vaddr = `FQH_VFY_FIRST;
                  s_nxt.fsm = ST_ISSUE;
               end else begin
                  s_nxt.refused = 1'b1;
               end
            end
         end
         ST_ISSUE: s_nxt.fsm = ST_WAIT;
         ST_WAIT: begin
            if (cyc_done) begin
               s_nxt.fsm = ST_ISSUE;
               if (!cyc.is_wr) s_nxt.rdata = cyc_rdata;
               if (s_r.op == OP_VERIFY && expect_w[16] && cyc_rdata != expect_w[15:0]) begin
                  if (!s_r.mismatch) s_nxt.mis_addr = s_r.vaddr;
                  s_nxt.mismatch = 1'b1;
               end
               if (!cyc.last) begin
                  s_nxt.step = s_r.step + 2'd1;
                  s_nxt.vaddr = s_r.vaddr + 7'h01;
               end else if (s_r.op == OP_POLL && cyc_rdata[`FQH_TIMEOUT_ERR_BIT]) begin
                  // the bank will not recover from a timed out operation by itself
                  s_nxt.op = OP_RESET;
                  s_nxt.err_reset = 1'b1;
               end else begin
                  s_nxt.fsm = ST_IDLE;
                  s_nxt.done = 1'b1;
                  unique case (s_r.op)
                     OP_RESET: s_nxt.mode = MD_READ;
                     OP_AUTOSEL: s_nxt.mode = MD_AUTOSEL;
                     OP_QUERY: s_nxt.mode = MD_QUERY;
                     default: s_nxt.mode = s_r.mode;
                  endcase
               end
            end
         end
         default: s_nxt.fsm = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         s_r <= '0;
         s_r.fsm <= ST_IDLE;
         s_r.op <= OP_READ;
         s_r.mode <= MD_READ;
      end else begin
         s_r <= s_nxt;
      end
   end

   fqh_bus_cycle i_fqh_bus_cycle (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .go_in(cyc_go),
      .cyc_in(cyc),
      .done_out(cyc_done),
      .rdata_out(cyc_rdata),
      .pins_out(pins),
      .dq_in(flash_dq_in)
   );

   assign prdata_out = s_r.prdata;
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && !mapped;
   assign flash_cs_n_out = pins.cs_n;
   assign flash_we_n_out = pins.we_n;
   assign flash_oe_n_out = pins.oe_n;
   assign flash_addr_out = pins.addr;
   assign flash_dq_out = pins.dq_out;
   assign flash_dq_oe_out = pins.dq_oe;
endmodule

//--- dv/fqh_host_assertions.sv
// pin and apb timing checks for the flash query host
`timescale 1ns/1ps
`include "fqh_consts.svh"
module fqh_host_assertions (
   // clock, reset and apb
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic [7:0] paddr_in,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // flash pins
   input wire logic flash_cs_n_out,
   input wire logic flash_we_n_out,
   input wire logic flash_oe_n_out,
   input wire logic [`FQH_AW-1:0] flash_addr_out,
   input wire logic [`FQH_DW-1:0] flash_dq_out,
   input wire logic flash_dq_oe_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   property p_we_frame;
      !flash_we_n_out |-> !flash_cs_n_out && flash_oe_n_out && flash_dq_oe_out;
   endproperty
   a_we_frame: assert property (p_we_frame) else $error("write strobe outside a write frame");
   property p_we_width;
      $fell(flash_we_n_out) |-> !flash_we_n_out [*4] ##[1:2] flash_we_n_out;
   endproperty
   a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
   property p_we_setup;
      $fell(flash_we_n_out) |-> $past(!flash_cs_n_out) && $past(flash_dq_oe_out);
   endproperty
   a_we_setup: assert property (p_we_setup) else $error("no setup before write strobe");
   property p_we_stable;
      !flash_we_n_out && $past(!flash_we_n_out) |-> $stable(flash_addr_out) && $stable(flash_dq_out);
   endproperty
   a_we_stable: assert property (p_we_stable) else $error("address or data moved under strobe");
   property p_we_hold;
      $rose(flash_we_n_out) |-> !flash_cs_n_out && flash_dq_oe_out && $stable(flash_dq_out);
   endproperty
   a_we_hold: assert property (p_we_hold) else $error("data not held past strobe rise");
   property p_rd_frame;
      !flash_oe_n_out |-> !flash_cs_n_out && !flash_dq_oe_out && flash_we_n_out;
   endproperty
   a_rd_frame: assert property (p_rd_frame) else $error("read strobe outside a read frame");
   property p_rd_width;
      $fell(flash_oe_n_out) |-> !flash_oe_n_out [*8];
   endproperty
   a_rd_width: assert property (p_rd_width) else $error("read strobe too short");
   property p_rd_addr;
      !flash_oe_n_out && $past(!flash_oe_n_out) |-> $stable(flash_addr_out);
   endproperty
   a_rd_addr: assert property (p_rd_addr) else $error("address moved during read");
   property p_pready;
      psel_in && penable_in |-> pready_out && (pslverr_out == (paddr_in > 8'h14 || paddr_in[1:0] != 2'b00));
   endproperty
   a_pready: assert property (p_pready) else $error("wrong ready or error response");
   property p_unmapped;
      psel_in && penable_in && paddr_in > 8'h14 |-> pslverr_out;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access without error");
   c_write: cover property ($fell(flash_we_n_out));
   c_read: cover property ($fell(flash_oe_n_out));
   c_err: cover property (psel_in && penable_in && pslverr_out);
endmodule
bind fqh_host fqh_host_assertions i_fqh_host_assertions (
   .core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
   .paddr_in(paddr_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
   .flash_cs_n_out(flash_cs_n_out), .flash_we_n_out(flash_we_n_out), .flash_oe_n_out(flash_oe_n_out),
   .flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out), .flash_dq_oe_out(flash_dq_oe_out)
);

//--- dv/fqh_flash_model.sv
// behavioural flash device answering command, autoselect and query cycles
`timescale 1ns/1ps
`include "fqh_consts.svh"
module fqh_flash_model #(
   parameter logic [22:0] U1A = 23'h0,
   parameter logic [22:0] U2A = 23'h0,
   parameter logic [15:0] U1D = 16'h0,
   parameter logic [15:0] U2D = 16'h0,
   parameter logic [15:0] ASD = 16'h0,
   parameter logic [15:0] RSD = 16'h0,
   parameter logic [15:0] ID_CODE = 16'h00a5 // arbitrary identification value
) (
   // bus pins
   input wire logic cs_n_in,
   input wire logic we_n_in,
   input wire logic oe_n_in,
   input wire logic [22:0] addr_in,
   input wire logic [15:0] dq_in,
   output logic [15:0] dq_out,
   // fault injection
   input wire logic err_in,
   input wire logic [6:0] bad_loc_in
);
   logic [22:0] lat_addr;
   logic [22:0] last_addr;
   logic [15:0] last_data;
   logic [1:0] seq = 2'd0;
   logic [1:0] mode = 2'd0;
   wire wr_act = !cs_n_in && !we_n_in && oe_n_in;
   function automatic logic [15:0] qword(input logic [7:0] a);
      case (a)
         8'h27: return 16'h0018;
         8'h28, 8'h34, 8'h47, 8'h48, 8'h4f, 8'h50: return 16'h0001;
         8'h2c: return 16'h0003;
         8'h2d, 8'h35, 8'h49: return 16'h0007;
         8'h2f, 8'h37: return 16'h0020;
         8'h31: return 16'h00fd;
         8'h40: return 16'h0050;
         8'h41: return 16'h0052;
         8'h42: return 16'h0049;
         8'h43: return 16'h0031;
         8'h44: return 16'h0033;
         8'h45: return 16'h000c;
         8'h46, 8'h4c: return 16'h0002;
         8'h4a: return 16'h00e7;
         8'h4d: return 16'h0085;
         8'h4e: return 16'h0095;
         8'h57: return 16'h0004;
         8'h58, 8'h5b: return 16'h0027;
         8'h59, 8'h5a: return 16'h0060;
         default: return 16'h0000;
      endcase
   endfunction
   function automatic logic [15:0] rword(input logic [22:0] a);
      if (mode == 2'd2)
         return qword(a[7:0]) ^ ((a[6:0] == bad_loc_in) ? 16'h0100 : 16'h0000);
      if (mode == 2'd1)
         return ID_CODE;
      return {a[15:6], err_in, a[4:0]};
   endfunction
   // undriven bus inverts on every change of cs, oe, address, mode or fault inputs, so after two changes it shows the last word again
   initial dq_out = 16'h0;
   always @(cs_n_in or oe_n_in or addr_in or mode or err_in or bad_loc_in) begin
      if (!cs_n_in && !oe_n_in)
         dq_out = rword(addr_in);
      else
         dq_out = ~dq_out;
   end
   always @(posedge wr_act) lat_addr = addr_in;
   always @(negedge wr_act) begin
      last_addr = lat_addr;
      last_data = dq_in;
      if (dq_in == RSD) begin
         mode = 2'd0;
         seq = 2'd0;
      end else if (lat_addr == `FQH_QUERY_ADDR && dq_in == `FQH_QUERY_DATA) begin
         mode = 2'd2;
         seq = 2'd0;
      end else if (seq == 2'd0 && lat_addr == U1A && dq_in == U1D)
         seq = 2'd1;
      else if (seq == 2'd1 && lat_addr == U2A && dq_in == U2D)
         seq = 2'd2;
      else if (seq == 2'd2 && dq_in == ASD && mode == 2'd0) begin
         mode = 2'd1;
         seq = 2'd0;
      end else
         seq = 2'd0;
   end
endmodule

//--- dv/fqh_host_bench.sv
// self-checking bench: flash query host against the flash model
`timescale 1ns/1ps
`include "fqh_consts.svh"
module fqh_host_bench;
   localparam logic [22:0] U1A = 23'h000111;
   localparam logic [22:0] U2A = 23'h000222;
   localparam logic [15:0] U1D = 16'h0011;
   localparam logic [15:0] U2D = 16'h0022;
   localparam logic [15:0] ASD = 16'h0033;
   localparam logic [15:0] RSD = 16'h00ff;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic err = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [6:0] bad = 7'h00;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd;
   logic prdy, perr, cs_n, we_n, oe_n, dq_oe;
   logic [22:0] fa;
   logic [15:0] fdo, fdi;
   int mismatches = 0;
   int n_compared = 0;
   int cyc = 0;
   wire [15:0] dq_bus = dq_oe ? fdo : fdi;
   always #5 core_clk_in = ~core_clk_in;
   fqh_host #(.UNLOCK1_ADDR(U1A), .UNLOCK1_DATA(U1D), .UNLOCK2_ADDR(U2A), .UNLOCK2_DATA(U2D),
      .AUTOSEL_DATA(ASD), .RESET_DATA(RSD)) i_fqh_host (
      .core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
      .flash_cs_n_out(cs_n), .flash_we_n_out(we_n), .flash_oe_n_out(oe_n), .flash_addr_out(fa),
      .flash_dq_out(fdo), .flash_dq_oe_out(dq_oe), .flash_dq_in(dq_bus));
   fqh_flash_model #(.U1A(U1A), .U2A(U2A), .U1D(U1D), .U2D(U2D), .ASD(ASD), .RSD(RSD)) i_fqh_flash_model (
      .cs_n_in(cs_n), .we_n_in(we_n), .oe_n_in(oe_n), .addr_in(fa), .dq_in(dq_bus), .dq_out(fdi),
      .err_in(err), .bad_loc_in(bad));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      @(posedge core_clk_in);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge core_clk_in);
      pen <= 1'b1;
      do begin
         @(posedge core_clk_in);
      end while (prdy !== 1'b1);
      r = prd;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask
   // start an operation, wait for done or refused, then clear the sticky flags
   task automatic op(input logic [2:0] o, input logic [1:0] f, output logic [31:0] s);
      wr(8'h00, {26'h0, f, o, 1'b1});
      do begin
         rd(8'h10, s);
      end while (s[2:1] === 2'b00);
      wr(8'h10, 32'h1e);
   endtask
   task automatic t_basic;
      logic [31:0] r, s;
      logic e;
      rd(8'h10, r);
      chk("status after reset", r, 32'h0);
      apb(1'b1, 8'h1c, 32'hffff_ffff, r, e);
      chk("write error", 32'(e), 32'h1);
      apb(1'b0, 8'h18, 32'h0, r, e);
      chk("read error", 32'(e), 32'h1);
      chk("unmapped read", r, 32'h0);
      wr(8'h04, 32'h1234);
      op(3'd0, 2'b00, s);
      rd(8'h0c, r);
      chk("array word", r, 32'h1214);
      wr(8'h04, 32'h2aaa);
      wr(8'h08, 32'h0c5a);
      op(3'd1, 2'b00, s);
      chk("latched address", 32'(i_fqh_flash_model.last_addr), 32'h2aaa);
      chk("latched data", 32'(i_fqh_flash_model.last_data), 32'h0c5a);
      op(3'd5, 2'b00, s);
      chk("verify outside query", 32'(s[2]), 32'h1);
      op(3'd7, 2'b00, s);
      chk("illegal op", 32'(s[2]), 32'h1);
      op(3'd3, 2'b01, s);
      chk("autoselect other bank busy", 32'(s[2]), 32'h1);
   endtask
   task automatic t_modes;
      logic [7:0] loc [8] = '{8'h27, 8'h2c, 8'h31, 8'h40, 8'h45, 8'h4a, 8'h57, 8'h5b};
      logic [15:0] val [8] = '{16'h18, 16'h03, 16'hfd, 16'h50, 16'h0c, 16'he7, 16'h04, 16'h27};
      logic [31:0] r, s;
      wr(8'h04, 32'h40_0000);
      op(3'd3, 2'b00, s);
      chk("mode autoselect", 32'(s[6:5]), 32'h1);
      repeat (2) begin
         op(3'd0, 2'b00, s);
         rd(8'h0c, r);
         chk("autoselect code", r, 32'h00a5);
      end
      op(3'd4, 2'b00, s);
      chk("mode query", 32'(s[6:5]), 32'h2);
      op(3'd4, 2'b00, s);
      chk("query twice", 32'(s[2]), 32'h1);
      for (int i = 0; i < 8; i++) begin
         wr(8'h04, 32'(loc[i]));
         op(3'd0, 2'b00, s);
         rd(8'h0c, r);
         chk("query word", r, 32'(val[i]));
      end
      op(3'd5, 2'b00, s);
      chk("verify clean", 32'(s[3:1]), 32'h1);
      op(3'd2, 2'b00, s);
      chk("mode after reset", 32'(s[6:5]), 32'h0);
      chk("device mode", 32'(i_fqh_flash_model.mode), 32'h0);
   endtask
   task automatic t_faults;
      logic [6:0] bl [3] = '{7'h27, 7'h3a, 7'h5b};
      logic [31:0] r, s;
      foreach (bl[i]) begin
         bad <= bl[i];
         op(3'd4, 2'b00, s);
         op(3'd5, 2'b00, s);
         chk("verify mismatch", 32'(s[3]), 32'h1);
         rd(8'h14, r);
         chk("mismatch location", r, 32'(bl[i]));
         op(3'd2, 2'b00, s);
      end
      bad <= 7'h00;
      err <= 1'b1;
      wr(8'h04, 32'h100);
      op(3'd6, 2'b00, s);
      chk("error reset flag", 32'(s[4]), 32'h1);
      chk("reset command sent", 32'(i_fqh_flash_model.last_data), 32'(RSD));
      err <= 1'b0;
      op(3'd2, 2'b10, s);
      chk("suspend read", 32'(s[7]), 32'h1);
   endtask
   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ceiling well above the few thousand cycles that the scenarios need
   always @(posedge core_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         mismatches++;
         summarize();
      end
   end
   initial begin
      repeat (5) @(posedge core_clk_in);
      rst_in <= 1'b0;
      t_basic();
      t_modes();
      t_faults();
      summarize();
   end
endmodule
